// file: hdl/pll_soft_reset_sysconfig.sv
// Clock and system control: PLL control, lock counter, soft reset and
// pending/active system configuration registers.
// Assumes core I/O reads and writes synchronous to clk_sys_i.
// A low ce_i freezes every register, the lock count included.
//
// Summary of operation
// - Reset leaves core clock bypassing the PLL
// - PLL ratio set; multiplier only after lock
// - Ten-bit lock counter times ratio change
// - Lock reported active while reset asserted
// - Writing seven to code fires soft reset
// - Trigger bits 3 to 15 ignored
// - Soft reset spares PLL and its control
// - Soft reset clears peripherals, stops DMA
// - Pending config held until soft reset
// - Soft reset copies pending into active
// - Pending config loaded from boot pins at reset
// - Active config read-write, same layout
// - Vector base selects one of two addresses
// - Port select picks serial or SPI, boot msb
// - Boot select bits choose boot mode
`timescale 1ns/1ps
module pll_soft_reset_sysconfig (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Core I/O register access
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [sysctl_pkg::ADDR_W-1:0] io_addr_i,
  input wire logic [sysctl_pkg::DATA_W-1:0] io_wdata_i,
  output logic [sysctl_pkg::DATA_W-1:0] io_rdata_o,
  // Mode pins
  input wire logic vector_base_select_i,
  input wire logic port_set_select_i,
  input wire logic [1:0] boot_select_low_i,
  // PLL side
  input wire logic pll_ready_i,
  output logic pll_bypass_o,
  output logic [sysctl_pkg::PLL_RATIO_W-1:0] pll_ratio_o,
  output logic pll_locked_o,
  // System reset and configuration
  output logic soft_reset_o,
  output logic dma_abort_o,
  output logic [1:0] boot_mode_o,
  output logic spi_ports_sel_o,
  output logic [16:0] vector_base_o
);
  import sysctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register select: true when the bus address names the given register
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    return (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [DATA_W-1:0] pll_control_r;
  logic [LOCK_W-1:0] lock_counter_r;
  logic [DATA_W-1:0] pending_sys_config_r;
  logic [DATA_W-1:0] active_sys_config_r;
  logic [DATA_W-1:0] rdata_r;
  logic strap_pend_r;
  logic bypass_r;
  logic [PLL_RATIO_W-1:0] ratio_r;
  logic locked_r;
  logic soft_pulse_r;
  logic [1:0] boot_r;
  logic spi_r;
  logic [16:0] vec_r;
  logic lock_ok;
  logic soft_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write strobes and the read mux
  wire hit_pll = addr_hit(io_addr_i, OFF_PLL_CONTROL);
  wire hit_lock = addr_hit(io_addr_i, OFF_LOCK_COUNTER);
  wire hit_srst = addr_hit(io_addr_i, OFF_SOFT_RESET_TRIGGER);
  wire hit_pend = addr_hit(io_addr_i, OFF_PENDING_SYS_CONFIG);
  wire hit_act = addr_hit(io_addr_i, OFF_ACTIVE_SYS_CONFIG);

  // Write strobes, one per register
  wire wr_pll = io_wr_i && hit_pll;
  wire wr_lock = io_wr_i && hit_lock;
  wire wr_srst = io_wr_i && hit_srst;
  wire wr_pend = io_wr_i && hit_pend;
  wire wr_act = io_wr_i && hit_act;

  // Ratio change restarts the lock timer
  // Rewriting the same ratio leaves the lock state alone
  wire [PLL_RATIO_W-1:0] new_ratio =
    io_wdata_i[PLL_RATIO_LSB +: PLL_RATIO_W];
  wire ratio_change = wr_pll &&
    (new_ratio != pll_control_r[PLL_RATIO_LSB +: PLL_RATIO_W]);

  // Leaving bypass is refused until lock is reported
  wire leave_bypass = ~io_wdata_i[PLL_BYPASS_BIT];
  wire bypass_next = (leave_bypass && lock_ok && !ratio_change) ?
    1'b0 : 1'b1;

  // Configuration value captured from the mode pins
  wire [DATA_W-1:0] strap_cfg = {
    {(DATA_W - CFG_USED_W){1'b0}},
    vector_base_select_i,
    port_set_select_i,
    boot_select_low_i
  };

  // Read mux; trigger register reads as zero
  // Unmapped offsets read as zero as well
  wire [DATA_W-1:0] rd_mux =
    hit_pll ? pll_control_r :
    hit_lock ?
      {{(DATA_W - LOCK_W){1'b0}}, lock_counter_r} :
    hit_pend ? pending_sys_config_r :
    hit_act ? active_sys_config_r :
    {DATA_W{1'b0}};

  // Decoded configuration fields
  wire [1:0] act_boot = active_sys_config_r[CFG_BOOT_LSB +: CFG_BOOT_W];
  wire act_port = active_sys_config_r[CFG_PORT_BIT];
  wire act_vec = active_sys_config_r[CFG_VEC_BIT];
  wire [16:0] vec_sel = act_vec ? VEC_BASE_HI : VEC_BASE_LO;

  // Next values of registers and registered outputs
  wire [DATA_W-1:0] rdata_nxt = io_rd_i ? rd_mux : {DATA_W{1'b0}};
  wire locked_nxt = lock_ok & pll_ready_i;
  wire [DATA_W-1:0] pll_control_nxt =
    {io_wdata_i[DATA_W-1:1], bypass_next};

  ////////////////////////////////////////////////////////////////////////
  // Lock timer
  // The count restarts on every ratio change, even mid count
  lock_timer #(
    .WIDTH(LOCK_W)
  ) u_lock (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .start_i(ratio_change),
    .load_i(lock_counter_r),
    .locked_o(lock_ok)
  );

  // Soft reset pulse generator, code in bits 2..0 only
  soft_reset_gen u_srst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .wr_i(wr_srst),
    .code_i(io_wdata_i[SRST_CODE_W-1:0]),
    .pulse_o(soft_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // PLL control: hardware reset only, a soft reset leaves it alone
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pll_control_r <= PLL_CONTROL_RST;
    end else if (ce_i && wr_pll) begin
      pll_control_r <= pll_control_nxt;
    end
  end

  // Lock counter reload value: hardware reset only
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      lock_counter_r <= LOCK_COUNTER_RST;
    end else if (ce_i && wr_lock) begin
      lock_counter_r <= io_wdata_i[LOCK_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap request: pending config captured the cycle after reset release
  // Pins are sampled after release, so they may settle during reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strap_pend_r <= 1'b1;
    end else if (ce_i) begin
      strap_pend_r <= 1'b0;
    end
  end

  // Pending configuration
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pending_sys_config_r <= '0;
    end else if (ce_i) begin
      if (strap_pend_r) begin
        pending_sys_config_r <= strap_cfg;
      end else if (wr_pend) begin
        pending_sys_config_r <= io_wdata_i;
      end
    end
  end

  // Active configuration
  // A soft reset copy wins over a direct write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      active_sys_config_r <= '0;
    end else if (ce_i) begin
      if (strap_pend_r) begin
        active_sys_config_r <= strap_cfg;
      end else if (soft_pulse) begin
        active_sys_config_r <= pending_sys_config_r;
      end else if (wr_act) begin
        active_sys_config_r <= io_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: stands one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Clock source select; bypass is the reset state
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bypass_r <= 1'b1;
    end else if (ce_i) begin
      bypass_r <= pll_control_r[PLL_BYPASS_BIT];
    end
  end

  // Multiplication ratio to the PLL
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ratio_r <= '0;
    end else if (ce_i) begin
      ratio_r <= pll_control_r[PLL_RATIO_LSB +: PLL_RATIO_W];
    end
  end

  // Lock indication, forced active while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      locked_r <= 1'b1;
    end else if (ce_i) begin
      locked_r <= locked_nxt;
    end
  end

  // Soft reset pulse, one cycle per qualifying write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      soft_pulse_r <= 1'b0;
    end else if (ce_i) begin
      soft_pulse_r <= soft_pulse;
    end
  end

  // Boot mode from the active configuration
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      boot_r <= '0;
    end else if (ce_i) begin
      boot_r <= act_boot;
    end
  end

  // Port set select from the active configuration
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      spi_r <= 1'b0;
    end else if (ce_i) begin
      spi_r <= act_port;
    end
  end

  // Interrupt vector table base from the active configuration
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vec_r <= VEC_BASE_LO;
    end else if (ce_i) begin
      vec_r <= vec_sel;
    end
  end

  // Outputs straight from the flip-flops
  assign io_rdata_o = rdata_r;
  assign pll_bypass_o = bypass_r;
  assign pll_ratio_o = ratio_r;
  assign pll_locked_o = locked_r;
  assign soft_reset_o = soft_pulse_r;
  assign dma_abort_o = soft_pulse_r;
  assign boot_mode_o = boot_r;
  assign spi_ports_sel_o = spi_r;
  assign vector_base_o = vec_r;

endmodule

// file: hdl/sysctl_pkg.sv
// Package: register map, field layout and timing constants for the
// clock and system control block.
// Assumes 16-bit I/O-mapped register access from the core.
package sysctl_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 10;
  localparam int LOCK_W = 10;

  // Register offsets in I/O page 0
  localparam logic [9:0] OFF_PLL_CONTROL = 10'h200;
  localparam logic [9:0] OFF_LOCK_COUNTER = 10'h201;
  localparam logic [9:0] OFF_SOFT_RESET_TRIGGER = 10'h202;
  localparam logic [9:0] OFF_PENDING_SYS_CONFIG = 10'h203;
  localparam logic [9:0] OFF_ACTIVE_SYS_CONFIG = 10'h204;

  // Pll_control fields
  localparam int PLL_BYPASS_BIT = 0;
  localparam int PLL_RATIO_LSB = 1;
  localparam int PLL_RATIO_W = 5;
  localparam logic [15:0] PLL_CONTROL_RST = 16'h0001;

  // Soft reset code field
  localparam int SRST_CODE_W = 3;
  localparam logic [2:0] SRST_CODE_FIRE = 3'h7;

  // System configuration fields
  localparam int CFG_BOOT_LSB = 0;
  localparam int CFG_BOOT_W = 2;
  localparam int CFG_PORT_BIT = 2;
  localparam int CFG_VEC_BIT = 3;
  localparam int CFG_USED_W = 4;

  // Interrupt vector table bases
  localparam logic [16:0] VEC_BASE_LO = 17'h00000;
  localparam logic [16:0] VEC_BASE_HI = 17'h10000;

  // Reset pulse length and lock counter default
  localparam int RESET_MIN_CYC = 4;
  localparam logic [9:0] LOCK_COUNTER_RST = 10'h200;

  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_COUNT = 2'b01
  } lock_state_t;

endpackage

// file: hdl/lock_timer.sv
// Lock timer: counts down from a programmed value after a ratio change.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module lock_timer #(
  parameter int WIDTH = sysctl_pkg::LOCK_W
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Control
  input wire logic start_i,
  input wire logic [WIDTH-1:0] load_i,
  // Status
  output logic locked_o
);
  import sysctl_pkg::*;

  lock_state_t state_r;
  logic [WIDTH-1:0] count_r;
  wire done = (count_r == '0);

  ////////////////////////////////////////////////////////////////////////
  // Countdown; lock forced active during reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= LK_LOCKED;
      count_r <= '0;
    end else if (ce_i) begin
      unique case (state_r)
        LK_LOCKED: begin
          if (start_i) begin
            state_r <= LK_COUNT;
            count_r <= load_i;
          end
        end
        LK_COUNT: begin
          if (start_i) begin
            count_r <= load_i;
          end else if (done) begin
            state_r <= LK_LOCKED;
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
        default: state_r <= LK_LOCKED;
      endcase
    end
  end

  assign locked_o = (state_r == LK_LOCKED);

endmodule

// file: hdl/soft_reset_gen.sv
// Soft reset generator: one-cycle pulse per qualifying trigger write.
// Assumes write strobe and data are synchronous to the clock.
`timescale 1ns/1ps
module soft_reset_gen (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Trigger write
  input wire logic wr_i,
  input wire logic [sysctl_pkg::SRST_CODE_W-1:0] code_i,
  // Pulse
  output logic pulse_o
);
  import sysctl_pkg::*;

  logic pulse_r;
  wire fire = wr_i && (code_i == SRST_CODE_FIRE);

  ////////////////////////////////////////////////////////////////////////
  // Self-clearing pulse; held while ce_i is low, a trigger write made while ce_i is low is dropped
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pulse_r <= 1'b0;
    end else if (ce_i) begin
      pulse_r <= fire;
    end
  end

  assign pulse_o = pulse_r;

endmodule

// file: verif/pll_sysctl_properties.sv
// Checker: port-level properties of the clock and system control block.
// Assumes it is bound onto the top module, one clock, ce_i held high.
`timescale 1ns/1ps
module sysctl_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register access
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [sysctl_pkg::ADDR_W-1:0] io_addr_i,
  input wire logic [sysctl_pkg::DATA_W-1:0] io_wdata_i,
  input wire logic [sysctl_pkg::DATA_W-1:0] io_rdata_o,
  // Watched outputs
  input wire logic pll_bypass_o,
  input wire logic pll_locked_o,
  input wire logic soft_reset_o,
  input wire logic dma_abort_o,
  input wire logic [16:0] vector_base_o
);
  import sysctl_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Decoded write requests
  wire logic fire_w = io_wr_i && io_addr_i == OFF_SOFT_RESET_TRIGGER &&
    io_wdata_i[2:0] == SRST_CODE_FIRE;
  wire logic act_w = io_wr_i && io_addr_i == OFF_ACTIVE_SYS_CONFIG;
  ////////////////////////////////////////////////////////////
  bypass_at_reset_a: assert property ($fell(reset_i) |-> pll_bypass_o)
    else $error("bypass low after reset");
  lock_at_reset_a: assert property ($fell(reset_i) |-> pll_locked_o)
    else $error("lock low after reset");
  fire_pulse_a: assert property (fire_w |-> ##2 soft_reset_o
    ##1 !soft_reset_o) else $error("soft reset pulse wrong");
  pulse_cause_a: assert property (soft_reset_o |-> $past(fire_w, 2))
    else $error("soft reset without trigger");
  abort_tracks_a: assert property (dma_abort_o == soft_reset_o)
    else $error("dma abort differs from soft reset");
  trig_read_a: assert property (io_rd_i &&
    io_addr_i == OFF_SOFT_RESET_TRIGGER |=> io_rdata_o == 16'h0000)
    else $error("trigger register readable");
  vec_follow_a: assert property (act_w && !$past(fire_w) &&
    !$past(fire_w, 2) |-> ##2 vector_base_o ==
    ($past(io_wdata_i[3], 2) ? VEC_BASE_HI : VEC_BASE_LO))
    else $error("vector base wrong");
  soft_spares_a: assert property (soft_reset_o |=>
    $stable(pll_bypass_o)) else $error("soft reset moved bypass");
endmodule
bind pll_soft_reset_sysconfig sysctl_props props (.clk_sys_i, .reset_i,
  .io_wr_i, .io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .pll_bypass_o,
  .pll_locked_o, .soft_reset_o, .dma_abort_o, .vector_base_o);

// file: verif/pll_soft_reset_sysconfig_test.sv
// Testbench: register and output checks of the clock and system control.
// Assumes the package, design modules and checker are compiled first.
`timescale 1ns/1ps
module pll_soft_reset_sysconfig_test;
  import sysctl_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, ce_i = 1, io_wr_i = 0, io_rd_i = 0;
  logic [9:0] io_addr_i = 0;
  logic [15:0] io_wdata_i = 0, io_rdata_o, d, p, s;
  logic vector_base_select_i = 0, port_set_select_i = 0, pll_ready_i = 1;
  logic [1:0] boot_select_low_i = 0, boot_mode_o;
  logic [4:0] pll_ratio_o, r;
  logic [16:0] vector_base_o;
  logic pll_bypass_o, pll_locked_o, soft_reset_o, dma_abort_o;
  logic spi_ports_sel_o;
  int n_fail = 0, n_tests = 0, n_pulse = 0, n_abort = 0, n, lk;
  pll_soft_reset_sysconfig uut (.clk_sys_i, .reset_i, .ce_i, .io_wr_i,
    .io_rd_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .vector_base_select_i,
    .port_set_select_i, .boot_select_low_i, .pll_ready_i, .pll_bypass_o,
    .pll_ratio_o, .pll_locked_o, .soft_reset_o, .dma_abort_o, .boot_mode_o,
    .spi_ports_sel_o, .vector_base_o);
  // Clock, pulse counter and watchdog
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (soft_reset_o === 1'b1) n_pulse++;
    if (dma_abort_o === 1'b1) n_abort++;
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(logic [9:0] a, logic [15:0] v);
    tick(1);
    io_wr_i = 1;
    io_addr_i = a;
    io_wdata_i = v;
    tick(1);
    io_wr_i = 0;
  endtask
  task automatic rd(logic [9:0] a, output logic [15:0] v);
    tick(1);
    io_rd_i = 1;
    io_addr_i = a;
    tick(1);
    v = io_rdata_o;
    io_rd_i = 0;
  endtask
  // Expected outputs from a configuration word
  function automatic logic [16:0] vec(logic b);
    return b ? VEC_BASE_HI : VEC_BASE_LO;
  endfunction
  task automatic cfg_chk(logic [15:0] c);
    chk("boot", boot_mode_o, c[1:0]);
    chk("spi", spi_ports_sel_o, c[2]);
    chk("vec", vector_base_o, vec(c[3]));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h06cd));
    {vector_base_select_i, port_set_select_i, boot_select_low_i} =
      4'($urandom);
    tick(4);
    chk("rbyp", pll_bypass_o, 1);
    chk("rlock", pll_locked_o, 1);
    reset_i = 0;
    s = {12'h0, vector_base_select_i, port_set_select_i, boot_select_low_i};
    rd(OFF_PENDING_SYS_CONFIG, d);
    chk("pend", d, s);
    cfg_chk(s);
    rd(OFF_PLL_CONTROL, d);
    chk("pll", d, PLL_CONTROL_RST);
    rd(OFF_LOCK_COUNTER, d);
    chk("lcnt", d, LOCK_COUNTER_RST);
    $display("test reset done");
    // Ratio change with refused switch, lock count, then switch
    lk = 4 + $urandom % 20;
    r = 5'($urandom) | 5'h01;
    wr(OFF_LOCK_COUNTER, 16'(lk));
    wr(OFF_PLL_CONTROL, {10'h0, r, 1'b0});
    tick(1);
    chk("unlk", pll_locked_o, 0);
    for (n = 1; pll_locked_o !== 1'b1 && n < 60; n++) tick(1);
    chk("lkmin", n >= lk, 1);
    chk("lkmax", n <= lk + 4, 1);
    chk("ratio", pll_ratio_o, r);
    chk("refuse", pll_bypass_o, 1);
    wr(OFF_PLL_CONTROL, {10'h0, r, 1'b0});
    tick(1);
    chk("mult", pll_bypass_o, 0);
    pll_ready_i = 0;
    tick(2);
    chk("ready", pll_locked_o, 0);
    pll_ready_i = 1;
    $display("test pll done");
    // Pending held through codes 0..6, copied on code 7
    p = 16'($urandom);
    wr(OFF_PENDING_SYS_CONFIG, p);
    for (int c = 0; c < 7; c++) wr(OFF_SOFT_RESET_TRIGGER,
      {13'($urandom), 3'(c)});
    tick(3);
    chk("nofire", n_pulse, 0);
    chk("noabort", n_abort, 0);
    rd(OFF_PENDING_SYS_CONFIG, d);
    chk("hold", d, p);
    cfg_chk(s);
    wr(OFF_SOFT_RESET_TRIGGER, {13'($urandom), 3'h7});
    tick(3);
    chk("fire", n_pulse, 1);
    chk("abort", n_abort, 1);
    rd(OFF_ACTIVE_SYS_CONFIG, d);
    chk("copy", d, p);
    cfg_chk(p);
    rd(OFF_PLL_CONTROL, d);
    chk("keep", d, {10'h0, r, 1'b0});
    rd(OFF_LOCK_COUNTER, d);
    chk("lkeep", d, 16'(lk));
    rd(OFF_SOFT_RESET_TRIGGER, d);
    chk("wo", d, 0);
    $display("test soft reset done");
    // Direct active writes, both vector bases, unmapped read
    for (int k = 0; k < 2; k++) begin
      d = 16'($urandom);
      d[3] = k[0];
      wr(OFF_ACTIVE_SYS_CONFIG, d);
      tick(1);
      cfg_chk(d);
      rd(OFF_ACTIVE_SYS_CONFIG, p);
      chk("actrw", p, d);
    end
    rd(10'h205, d);
    chk("unmap", d, 0);
    $display("test active done");
    // Clock enable low freezes the lock output
    ce_i = 0;
    pll_ready_i = 0;
    tick(2);
    chk("freeze", pll_locked_o, 1);
    ce_i = 1;
    pll_ready_i = 1;
    tick(1);
    $display("test enable done");
    tally_and_finish();
  end
endmodule
